// ---- bench/bctu_mem_model.sv ----
// operand memory model facing the transpose unit
`timescale 1ns/10ps
`default_nettype none
module bctu_mem_model (
    // clock
    input wire logic clock_i,
    // memory port
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    output logic [15:0] mem_rdata_o
);
    logic [15:0] mem [256];
    initial mem_rdata_o = 16'hA5A5;
    // data valid only the cycle after a read; a toggling pattern otherwise, so stale data fails
    always @(posedge clock_i) begin
        if (mem_rd_i) begin
            mem_rdata_o <= mem[mem_addr_i[7:0]];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
        if (mem_wr_i) begin
            mem[mem_addr_i[7:0]] <= mem_wdata_i;
        end
    end
endmodule // bctu_mem_model
`default_nettype wire

// ---- bench/bctu_unit_tb_top.sv ----
// self-checking bench for the bit column transpose unit
`timescale 1ns/10ps
`default_nettype none
module bctu_unit_tb_top
    import bctu_pkg::*;
;
    typedef struct {logic f; logic z; logic b; logic [15:0] a; int n;
        logic [15:0] w[16];} bctu_note_t;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0, op_scatter_i = 1'b0, cond_i = 1'b0, ind_fault_i = 1'b0;
    logic [15:0] desig_i = 16'h0000, src_addr_i = 16'h0000, dst_addr_i = 16'h0000;
    logic [15:0] src_area_end_i = 16'h00FF, dst_area_end_i = 16'h00FF;
    logic busy_o, done_o, fault_flag_o, zero_result_flag_o, mem_rd_o, mem_wr_o;
    logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [15:0] sh [256];
    logic exp_f = 1'b0, exp_z = 1'b0;
    bctu_note_t notes [$];
    bctu_note_t mn;
    int failures = 0, check_count = 0;
    int busy_n = 0;
    always #2 clock_i = ~clock_i;
    bctu_unit bctu_unit_i (.clock_i, .reset_i, .start_i, .op_scatter_i, .cond_i, .ind_fault_i,
        .desig_i, .src_addr_i, .dst_addr_i, .src_area_end_i, .dst_area_end_i, .busy_o, .done_o,
        .fault_flag_o, .zero_result_flag_o, .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o,
        .mem_rdata_i);
    bctu_mem_model bctu_mem_model_i (.clock_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [15:0] bcd(input int c);
        return {8'h00, 4'(c / 10), 4'(c % 10)};
    endfunction
    // expected results are worked out here before the command is issued
    task automatic do_op(input logic op, input logic cnd, input logic ind, input logic [15:0] dg,
        input logic [15:0] s, input logic [15:0] d, input logic [15:0] se, input logic [15:0] de);
        bctu_note_t nt;
        logic bad;
        int c;
        c = dg[3:0] + 10 * dg[7:4];
        bad = dg[15:8] != 8'h00 || dg[3:0] > 4'h9 || dg[7:4] > 4'h1 || c > 15 || ind
            || (op ? d + 16'h000F > de : s + 16'h000F > se);
        nt.a = d;
        nt.n = op ? 16 : 1;
        nt.b = cnd && !bad;
        for (int n = 0; n < 16; n++) nt.w[n] = sh[d[7:0] + n];
        if (cnd && !bad) begin
            for (int n = 0; n < 16; n++) begin
                if (op) nt.w[n][c] = sh[s[7:0]][n];
                else nt.w[0][n] = sh[s[7:0] + n][c];
            end
            for (int n = 0; n < nt.n; n++) sh[d[7:0] + n] = nt.w[n];
            exp_f = 1'b0;
            exp_z = op ? sh[s[7:0]] == BCTU_ZERO_WORD : nt.w[0] == BCTU_ZERO_WORD;
        end else if (cnd) begin
            exp_f = 1'b1;
        end
        nt.f = exp_f;
        nt.z = exp_z;
        notes.push_back(nt);
        @(posedge clock_i);
        #1;
        {start_i, op_scatter_i, cond_i, ind_fault_i} = {1'b1, op, cnd, ind};
        {desig_i, src_addr_i, dst_addr_i, src_area_end_i, dst_area_end_i} = {dg, s, d, se, de};
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        // a second command while busy must be ignored
        repeat (4) @(posedge clock_i);
        #1;
        if (busy_o === 1'b1) {start_i, op_scatter_i} = {1'b1, ~op};
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        for (int k = 0; k < 300 && notes.size() != 0; k++) @(posedge clock_i);
        // a result that never comes ends the run as a failure
        if (notes.size() != 0) begin
            failures++;
            test_done();
        end
    endtask
    always @(posedge clock_i) begin
        if (busy_o === 1'b1) busy_n++;
        if (done_o === 1'b1) begin
            check(16'(notes.size() != 0), 16'h0001);
            check(16'(busy_o), 16'h0000);
            if (notes.size() != 0) begin
                mn = notes.pop_front();
                check(16'(fault_flag_o), 16'(mn.f));
                check(16'(zero_result_flag_o), 16'(mn.z));
                check(16'(busy_n != 0), 16'(mn.b));
                for (int i = 0; i < mn.n; i++)
                    check(bctu_mem_model_i.mem[8'(mn.a + i)], mn.w[i]);
            end
            busy_n = 0;
        end
    end
    initial begin
        #80000;
        failures++;
        test_done();
    end
    initial begin
        void'($urandom(63224));
        for (int i = 0; i < 256; i++) sh[i] = 16'($urandom());
        sh[60] = 16'h0000;
        for (int i = 0; i < 256; i++) bctu_mem_model_i.mem[i] = sh[i];
        repeat (12) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        for (int i = 0; i < 16; i++) begin
            do_op(1'b0, 1'b1, 1'b0, bcd(i), 16'(i), 16'(100 + i), 16'h00FF, 16'h00FF);
            do_op(1'b1, 1'b1, 1'b0, bcd(i), 16'(40 + i), 16'(120 + i), 16'h00FF, 16'h00FF);
        end
        do_op(1'b1, 1'b1, 1'b0, bcd(3), 16'd60, 16'd200, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b0, bcd(3), 16'd200, 16'd180, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b0, 1'b0, bcd(5), 16'd5, 16'd101, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b0, 16'h000A, 16'd5, 16'd102, 16'h00FF, 16'h00FF);
        do_op(1'b1, 1'b0, 1'b0, bcd(2), 16'd41, 16'd130, 16'h00FF, 16'h00FF);
        do_op(1'b1, 1'b1, 1'b0, 16'h0016, 16'd41, 16'd130, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b0, 16'h0100, 16'd5, 16'd102, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b0, bcd(7), 16'd10, 16'd103, 16'h0018, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b0, bcd(7), 16'd10, 16'd103, 16'h0019, 16'h0000);
        do_op(1'b1, 1'b1, 1'b0, bcd(9), 16'd42, 16'd170, 16'h0000, 16'h00B8);
        do_op(1'b1, 1'b1, 1'b0, bcd(9), 16'd42, 16'd170, 16'h0000, 16'h00B9);
        do_op(1'b1, 1'b1, 1'b1, bcd(1), 16'd43, 16'd140, 16'h00FF, 16'h00FF);
        do_op(1'b0, 1'b1, 1'b1, bcd(1), 16'd3, 16'd104, 16'h00FF, 16'h00FF);
        for (int i = 0; i < 8; i++)
            do_op(1'(i), 1'($urandom() % 4 != 0), 1'b0, bcd($urandom() % 16),
                16'(i[0] ? 40 + $urandom() % 16 : $urandom() % 16),
                16'(i[0] ? 120 + $urandom() % 16 : 100 + $urandom() % 16), 16'h00FF, 16'h00FF);
        test_done();
    end
endmodule // bctu_unit_tb_top
`default_nettype wire

// ---- design/bctu_bcd_check.sv ----
// bit designator check: two bcd digits naming a bit 00 to 15, upper byte zero
`timescale 1ns/10ps
`default_nettype none
module bctu_bcd_check
    import bctu_pkg::*;
(
    // designator in, verdict out
    input wire logic [BCTU_WORD_W-1:0] desig_i,
    output logic valid_o,
    output logic [BCTU_IDX_W-1:0] index_o
);
    logic [3:0] ones;
    logic [3:0] tens;
    assign ones = desig_i[3:0];
    assign tens = desig_i[7:4];
    assign valid_o = (desig_i[15:8] == 8'h00) && (tens <= BCTU_TENS_MAX) &&
                     (ones <= BCTU_DIGIT_MAX) &&
                     ((tens == 4'h0) || (ones <= BCTU_ONES_MAX_TEENS));
    // tens is 0 or 1 when valid, so ten plus ones fits four bits
    assign index_o = (tens == 4'h1) ? 4'(ones + 4'hA) : ones;
endmodule // bctu_bcd_check
`default_nettype wire

// ---- design/bctu_pkg.sv ----
// shared constants and types of the bit column transpose unit
package bctu_pkg;
    localparam int BCTU_WORD_W = 16;
    localparam int BCTU_ADDR_W = 16;
    localparam int BCTU_IDX_W = 4;
    localparam logic [BCTU_IDX_W-1:0] BCTU_LAST_IDX = 4'hF;
    localparam logic [BCTU_ADDR_W:0] BCTU_SPAN = 17'h0000F;
    localparam logic [3:0] BCTU_DIGIT_MAX = 4'h9;
    localparam logic [3:0] BCTU_TENS_MAX = 4'h1;
    localparam logic [3:0] BCTU_ONES_MAX_TEENS = 4'h5;
    localparam logic [BCTU_WORD_W-1:0] BCTU_ZERO_WORD = 16'h0000;
    typedef enum logic [2:0] {
        BCTU_IDLE,
        BCTU_RD,
        BCTU_RQ,
        BCTU_DT,
        BCTU_WRG,
        BCTU_WRS,
        BCTU_FIN
    } bctu_state_t;
endpackage

// ---- design/bctu_unit.sv ----
// bit column gather and scatter datapath
`timescale 1ns/10ps
`default_nettype none
module bctu_unit
    import bctu_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // command from the sequencer
    input wire logic start_i,
    input wire logic op_scatter_i,
    input wire logic cond_i,
    input wire logic ind_fault_i,
    input wire logic [BCTU_WORD_W-1:0] desig_i,
    input wire logic [BCTU_ADDR_W-1:0] src_addr_i,
    input wire logic [BCTU_ADDR_W-1:0] dst_addr_i,
    input wire logic [BCTU_ADDR_W-1:0] src_area_end_i,
    input wire logic [BCTU_ADDR_W-1:0] dst_area_end_i,
    // status
    output logic busy_o,
    output logic done_o,
    output logic fault_flag_o,
    output logic zero_result_flag_o,
    // operand memory
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [BCTU_ADDR_W-1:0] mem_addr_o,
    output logic [BCTU_WORD_W-1:0] mem_wdata_o,
    input wire logic [BCTU_WORD_W-1:0] mem_rdata_i
);
    bctu_state_t state_q;
    logic scatter_q;
    logic src_loaded_q;
    logic [BCTU_IDX_W-1:0] bit_q;
    logic [BCTU_IDX_W-1:0] idx_q;
    logic [BCTU_ADDR_W-1:0] src_q;
    logic [BCTU_ADDR_W-1:0] dst_q;
    logic [BCTU_WORD_W-1:0] acc_q;
    logic [BCTU_WORD_W-1:0] word_q;
    logic desig_ok;
    logic [BCTU_IDX_W-1:0] desig_bit;
    logic src_span_bad;
    logic dst_span_bad;
    logic any_fault;
    logic accept;
    logic [BCTU_WORD_W-1:0] bit_mask;

    bctu_bcd_check u_check (
        .desig_i(desig_i),
        .valid_o(desig_ok),
        .index_o(desig_bit)
    );

    // source set stays in one area
    assign src_span_bad = ({1'b0, src_addr_i} + BCTU_SPAN) > {1'b0, src_area_end_i};
    // destination set stays in one area
    assign dst_span_bad = ({1'b0, dst_addr_i} + BCTU_SPAN) > {1'b0, dst_area_end_i};
    assign any_fault = !desig_ok || ind_fault_i ||
                       (op_scatter_i ? dst_span_bad : src_span_bad);
    // only a true condition starts work
    assign accept = start_i && (state_q == BCTU_IDLE) && cond_i;
    assign bit_mask = BCTU_WORD_W'(1) << bit_q;

    // sequencing and memory port
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= BCTU_IDLE;
            scatter_q <= 1'b0;
            src_loaded_q <= 1'b0;
            bit_q <= '0;
            idx_q <= '0;
            src_q <= '0;
            dst_q <= '0;
            acc_q <= BCTU_ZERO_WORD;
            word_q <= BCTU_ZERO_WORD;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= BCTU_ZERO_WORD;
        end else begin
            done_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            case (state_q)
                BCTU_IDLE: begin
                    if (start_i) begin
                        scatter_q <= op_scatter_i;
                        bit_q <= desig_bit;
                        src_q <= src_addr_i;
                        dst_q <= dst_addr_i;
                        idx_q <= '0;
                        src_loaded_q <= 1'b0;
                        // a fault ends the command before any write
                        if (!cond_i || any_fault) begin
                            done_o <= 1'b1;
                        end else begin
                            busy_o <= 1'b1;
                            state_q <= BCTU_RD;
                        end
                    end
                end
                BCTU_RD: begin
                    mem_rd_o <= 1'b1;
                    if (!scatter_q) begin
                        mem_addr_o <= BCTU_ADDR_W'(src_q + BCTU_ADDR_W'(idx_q));
                    end else if (!src_loaded_q) begin
                        mem_addr_o <= src_q;
                    end else begin
                        mem_addr_o <= BCTU_ADDR_W'(dst_q + BCTU_ADDR_W'(idx_q));
                    end
                    state_q <= BCTU_RQ;
                end
                BCTU_RQ: begin
                    // read data returns the cycle after the request
                    state_q <= BCTU_DT;
                end
                BCTU_DT: begin
                    if (!scatter_q) begin
                        // gather bit C into bit n
                        acc_q[idx_q] <= mem_rdata_i[bit_q];
                        if (idx_q == BCTU_LAST_IDX) begin
                            state_q <= BCTU_WRG;
                        end else begin
                            idx_q <= 4'(idx_q + 4'h1);
                            state_q <= BCTU_RD;
                        end
                    end else if (!src_loaded_q) begin
                        word_q <= mem_rdata_i;
                        src_loaded_q <= 1'b1;
                        state_q <= BCTU_RD;
                    end else begin
                        mem_wr_o <= 1'b1;
                        mem_wdata_o <= (mem_rdata_i & ~bit_mask) |
                                       (word_q[idx_q] ? bit_mask : BCTU_ZERO_WORD);
                        state_q <= BCTU_WRS;
                    end
                end
                BCTU_WRG: begin
                    mem_wr_o <= 1'b1;
                    mem_addr_o <= dst_q;
                    mem_wdata_o <= acc_q;
                    state_q <= BCTU_FIN;
                end
                BCTU_WRS: begin
                    if (idx_q == BCTU_LAST_IDX) begin
                        state_q <= BCTU_FIN;
                    end else begin
                        idx_q <= 4'(idx_q + 4'h1);
                        state_q <= BCTU_RD;
                    end
                end
                BCTU_FIN: begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state_q <= BCTU_IDLE;
                end
                default: begin
                    state_q <= BCTU_IDLE;
                end
            endcase
        end
    end

    // result flags
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fault_flag_o <= 1'b0;
            zero_result_flag_o <= 1'b0;
        end else if (start_i && (state_q == BCTU_IDLE) && cond_i && any_fault) begin
            // fault reported alone, zero flag left as it was
            fault_flag_o <= 1'b1;
        end else if (state_q == BCTU_FIN) begin
            fault_flag_o <= 1'b0;
            zero_result_flag_o <= scatter_q ? (word_q == BCTU_ZERO_WORD) :
                                              (acc_q == BCTU_ZERO_WORD);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_cond_false_quiet: assert property (
        (start_i && state_q == BCTU_IDLE && !cond_i) |=>
        done_o && !busy_o && $stable(fault_flag_o) && $stable(zero_result_flag_o))
        else $error("condition false changed state");
    a_fault_no_write: assert property (
        (accept && any_fault) |=> done_o && fault_flag_o && !busy_o && !mem_wr_o
        && $stable(zero_result_flag_o))
        else $error("fault did not end command cleanly");
    a_bad_desig: assert property (
        (accept && !desig_ok) |=> fault_flag_o)
        else $error("bad designator not flagged");
    a_src_span: assert property (
        (accept && !op_scatter_i && src_span_bad) |=> fault_flag_o)
        else $error("source span fault missed");
    a_dst_span: assert property (
        (accept && op_scatter_i && dst_span_bad) |=> fault_flag_o)
        else $error("destination span fault missed");
    a_ind_fault: assert property (
        (accept && ind_fault_i) |=> fault_flag_o && !busy_o)
        else $error("indirect fault missed");
    a_gather_bit: assert property (
        (state_q == BCTU_DT && !scatter_q) |=>
        acc_q[$past(idx_q)] == $past(mem_rdata_i[bit_q]))
        else $error("gathered bit wrong");
    a_scatter_bit: assert property (
        (mem_wr_o && scatter_q) |-> mem_wdata_o[bit_q] == word_q[idx_q]
        && mem_addr_o == BCTU_ADDR_W'(dst_q + BCTU_ADDR_W'(idx_q)))
        else $error("scattered bit wrong");
    a_scatter_keep: assert property (
        (mem_wr_o && scatter_q) |-> (mem_wdata_o & ~bit_mask) ==
        ($past(mem_rdata_i) & ~bit_mask))
        else $error("other bits disturbed");
    a_gather_zero: assert property (
        (mem_wr_o && !scatter_q) |=>
        zero_result_flag_o == ($past(mem_wdata_o) == BCTU_ZERO_WORD) && done_o)
        else $error("gather zero flag wrong");
    a_scatter_zero: assert property (
        (done_o && scatter_q && $past(state_q) == BCTU_FIN) |->
        zero_result_flag_o == (word_q == BCTU_ZERO_WORD))
        else $error("scatter zero flag wrong");
    // three cycles a word for gather; scatter adds the source read and a write cycle per word
    a_gather_bound: assert property (
        (accept && !any_fault && !op_scatter_i) |-> ##51 done_o)
        else $error("gather did not finish in time");
    a_scatter_bound: assert property (
        (accept && !any_fault && op_scatter_i) |-> ##69 done_o)
        else $error("scatter did not finish in time");

    c_gather_done: cover property (done_o && !scatter_q && !fault_flag_o && busy_o == 1'b0);
    c_scatter_done: cover property ((state_q == BCTU_FIN) && scatter_q);
    c_fault: cover property (accept && any_fault);
    c_cond_false: cover property (start_i && state_q == BCTU_IDLE && !cond_i);
endmodule // bctu_unit
`default_nettype wire
